// [bench/spw_load.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Passive load that times the waveform between two rising edges
// ----------------------------------------------------------------------
module spw_load (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic             done,
  output logic [15:0]      per_cnt,
  output logic [15:0]      hi_cnt
);
  logic        lvl_d;
  logic        seen;
  logic [15:0] per_run;
  logic [15:0] hi_run;
  // The load only sees the pin while its driver is on.
  wire  logic  lvl = pin & oe;

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_d <= 1'b0;
      seen  <= 1'b0;
      done  <= 1'b0;
    end else begin
      lvl_d <= lvl;
      done  <= 1'b0;
      if (lvl && !lvl_d) begin
        per_run <= 16'h0001;
        hi_run  <= 16'h0001;
        seen    <= 1'b1;
        if (seen) begin
          done    <= 1'b1;
          per_cnt <= per_run;
          hi_cnt  <= hi_run;
        end
      end else begin
        per_run <= per_run + 16'h0001;
        if (lvl) begin
          hi_run <= hi_run + 16'h0001;
        end
      end
    end
  end
endmodule  // spw_load

// [bench/standard_pwm_channel_bench.sv]
`timescale 1ns/1ps
module standard_pwm_channel_bench;
  import spw_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  sleep = 1'b0;
  logic [TIMER_W-1:0]    lim [NUM_TIMERS];
  logic [1:0]            psel [NUM_TIMERS];
  logic [TIMER_W-1:0]    cnt [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] run = '0;
  logic [NUM_TIMERS-1:0] fclr = '0;
  logic [NUM_TIMERS-1:0] flag;
  logic [SEL_W-1:0]      sel = '0;
  logic                  cwe = 1'b0, swe = 1'b0, awe = 1'b0, dir = 1'b1;
  logic [CTRL_W-1:0]     cwd = '0, ctrl;
  logic [TIMER_W-1:0]    swd = '0, awd = '0, stg, act;
  logic                  pin, oe, done;
  logic [15:0]           per_cnt, hi_cnt;
  logic [31:0]           exp_q [$];
  logic [31:0]           e;
  int                    error_cnt = 0, comparisons = 0, seed = 32'h6407;
  int                    lv, d, p, n;

  always #2.5 clk = ~clk;

  spw_channel #(.NUM_TIMERS(NUM_TIMERS)) spw_channel_i (
    .clk(clk), .rst(rst), .sleep(sleep), .period_limit(lim), .prescale_select(psel),
    .timer_run_bit(run), .flag_clear(fclr), .period_counter(cnt), .timer_match_flag(flag),
    .timer_source_select(sel), .ctrl_wr_en(cwe), .ctrl_wr_data(cwd),
    .staging_wr_en(swe), .staging_wr_data(swd), .active_wr_en(awe),
    .active_wr_data(awd), .pin_direction_bit(dir), .channel_control(ctrl),
    .duty_staging_upper(stg), .duty_active_upper(act), .pwm_output_pin(pin),
    .pwm_output_oe(oe));

  spw_load spw_load_i (.clk(clk), .rst(rst), .pin(pin), .oe(oe), .done(done),
    .per_cnt(per_cnt), .hi_cnt(hi_cnt));

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Mismatches %0d in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The oldest note is taken only when the load reports a finished period.
  always @(negedge clk) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      check({per_cnt, hi_cnt}, exp_q.pop_front());
    end
  end

  // ----------------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_done;
    @(negedge clk);
    while (done !== 1'b1) @(negedge clk);
    tick(1);
  endtask

  task automatic wr(input int w, input logic [7:0] v);
    {cwd, swd, awd} = {v, v, v};
    cwe = (w == 0);
    swe = (w == 1);
    awe = (w == 2);
    tick(1);
    {cwe, swe, awe} = 3'h0;
    // An idle edge keeps a following write from re-driving the strobes at once.
    tick(1);
  endtask

  // A flag pulse clears every timer flag, then the selected one is awaited.
  task automatic wait_flag;
    fclr = '1;
    tick(1);
    fclr = '0;
    n = 0;
    while (flag[sel] !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    check(32'(flag[sel]), 32'h1);
  endtask

  task automatic cfg(input int k);
    sel = 2'(k % 3);
    foreach (lim[i]) begin
      lim[i] = 8'(3 + {$random(seed)} % 10);
      psel[i] = 2'(k);
    end
    lv = lim[sel];
    p = (k == 0) ? 1 : (k == 1) ? 4 : 16;
  endtask

  task automatic setup(input logic [9:0] dv);
    rst = 1'b1;
    dir = 1'b1;
    run = '0;
    tick(16);
    rst = 1'b0;
    tick(1);
    check({4'h0, ctrl, stg, act, oe, flag}, 32'h0);
    wr(0, {2'h0, dv[1:0], 4'hC});
    wr(1, dv[9:2]);
    check(32'({stg, ctrl[5:4]}), 32'(dv));
    run = '1;
    wait_flag();
    dir = 1'b0;
  endtask

  task automatic count_pin(input int k, input logic want);
    n = 0;
    repeat (k) begin
      tick(1);
      if (pin !== want) n++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    foreach (lim[i]) begin
      lim[i] = '0;
      psel[i] = '0;
    end
    for (int k = 0; k < 4; k++) begin
      cfg(k);
      d = 1 + {$random(seed)} % (4 * lv + 2);
      setup(10'(d));
      wait_done();
      exp_q.push_back({16'((lv + 1) * 4 * p), 16'(d * p + 1)});
      wait_done();
      check(32'(act), 32'(d >> 2));
      tick(1);
      wr(2, 8'hA5);
      check(32'(act), 32'(d >> 2));
      wr(1, 8'(d >> 2) ^ 8'h80);
      tick(2);
      check(32'(act), 32'(d >> 2));
      wait_flag();
      check(32'(act), 32'(8'(d >> 2) ^ 8'h80));
      sleep = 1'b1;
      e = {23'h0, cnt[sel], pin};
      tick(40);
      check({23'h0, cnt[sel], pin}, e);
      sleep = 1'b0;
      // The first step after wake must continue from the frozen count.
      n = 0;
      while (cnt[sel] === e[8:1] && n < 100) begin
        tick(1);
        n++;
      end
      check(32'(cnt[sel]), (e[8:1] == 8'(lv)) ? 32'h0 : 32'(e[8:1]) + 32'h1);
      wait_flag();
      wr(0, 8'h00);
      tick(2);
      check(32'({oe, pin}), 32'h0);
      wr(2, 8'h5A);
      check(32'(act), 32'h5A);
    end
    cfg(0);
    setup(10'h000);
    count_pin(8 * (lv + 1), 1'b0);
    check(32'(n), 32'h0);
    cfg(1);
    setup(10'h3FF);
    tick(1);
    count_pin(16 * (lv + 1), 1'b1);
    check(32'(n), 32'h0);
    // An unused select code must idle the channel, so no restart loads the new duty.
    sel = 2'h3;
    wr(1, 8'h00);
    tick(16 * (lv + 1) + 8);
    check(32'(act), 32'hFF);
    check(32'(exp_q.size()), 32'h0);
    stop_test();
  end

  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end
endmodule  // standard_pwm_channel_bench

// [rtl/spw_channel.sv]
// What this block does
// - Time base is counter plus two sub-count bits.
// - Prescale one-to-one takes sub bits from clock phase.
// - Active duty register read-only in pulse-width mode.
// - Two-bit select picks one of three timers.
// - Period is limit plus one, times four, times prescale.
// - Counter clears on step after reaching limit.
// - Pin set at period start unless duty zero.
// - Restart copies staged duty into active buffer.
// - No postscaler affects the period.
// - Duty is staging byte plus control bits 5:4.
// - Staged duty applies only at period end.
// - Active byte plus two-bit latch double buffer duty.
// - Pin cleared when time base equals active duty.
// - Duty beyond period leaves pin unchanged.
// - Sleep freezes counter, phase and duty timing; registers stay writable.
// - Wake resumes from the preserved counter value.
// - Resolution is log2 of four times limit plus one.
// - Prescaler divides by 1, 4 or 16.
// - Software waits for match flag before enabling pin.
// - Zero control register releases the pin.
// - Reset restores registers and sets pin to input.
`timescale 1ns/1ps

module spw_channel #(
  parameter int NUM_TIMERS = spw_pkg::NUM_TIMERS
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                sleep,
  input  wire logic [spw_pkg::TIMER_W-1:0]         period_limit [NUM_TIMERS],
  input  wire logic [1:0]                          prescale_select [NUM_TIMERS],
  input  wire logic [NUM_TIMERS-1:0]               timer_run_bit,
  input  wire logic [NUM_TIMERS-1:0]               flag_clear,
  output logic      [spw_pkg::TIMER_W-1:0]         period_counter [NUM_TIMERS],
  output logic      [NUM_TIMERS-1:0]               timer_match_flag,
  input  wire logic [spw_pkg::SEL_W-1:0]           timer_source_select,
  input  wire logic                                ctrl_wr_en,
  input  wire logic [spw_pkg::CTRL_W-1:0]          ctrl_wr_data,
  input  wire logic                                staging_wr_en,
  input  wire logic [spw_pkg::TIMER_W-1:0]         staging_wr_data,
  input  wire logic                                active_wr_en,
  input  wire logic [spw_pkg::TIMER_W-1:0]         active_wr_data,
  input  wire logic                                pin_direction_bit,
  output logic      [spw_pkg::CTRL_W-1:0]          channel_control,
  output logic      [spw_pkg::TIMER_W-1:0]         duty_staging_upper,
  output logic      [spw_pkg::TIMER_W-1:0]         duty_active_upper,
  output logic                                     pwm_output_pin,
  output logic                                     pwm_output_oe
);
  import spw_pkg::*;

  // ----------------------------------------------------------------------
  // Decoders shared by every timer
  // ----------------------------------------------------------------------
  function automatic logic [PRESC_W-1:0] presc_last(input logic [1:0] ps);
    case (ps)
      PRESC_SEL_1: presc_last = PRESC_LAST_1;
      PRESC_SEL_4: presc_last = PRESC_LAST_4;
      default:     presc_last = PRESC_LAST_16;
    endcase
  endfunction

  function automatic logic [SUB_W-1:0] sub_bits(input logic [1:0]         ps,
                                                input logic [SUB_W-1:0]   ph,
                                                input logic [PRESC_W-1:0] pc);
    case (ps)
      PRESC_SEL_1: sub_bits = ph;
      PRESC_SEL_4: sub_bits = pc[1:0];
      default:     sub_bits = pc[3:2];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Clock phase and the period timers
  // ----------------------------------------------------------------------
  logic [SUB_W-1:0]   phase_reg;
  logic [PRESC_W-1:0] presc_reg [NUM_TIMERS];
  logic [TIMER_W-1:0] cnt_reg   [NUM_TIMERS];
  logic [SUB_W-1:0]   sub       [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] flag_reg;
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] at_limit;

  // The phase stops in sleep as well, so a wake resumes mid-step exactly.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (!sleep) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    logic step_ok;
    assign step_ok  = timer_run_bit[t] && !sleep && (phase_reg == PHASE_LAST);
    assign tick[t]  = step_ok && (presc_reg[t] >= presc_last(prescale_select[t]));
    assign at_limit[t] = (cnt_reg[t] == period_limit[t]);
    assign sub[t]   = sub_bits(prescale_select[t], phase_reg, presc_reg[t]);
    assign period_counter[t] = cnt_reg[t];

    always_ff @(posedge clk) begin
      if (rst) begin
        presc_reg[t] <= 4'h0;
      end else if (step_ok) begin
        presc_reg[t] <= tick[t] ? 4'h0 : presc_reg[t] + 4'h1;
      end
    end

    // No postscaler sits in this path; the period depends on limit and prescale only.
    always_ff @(posedge clk) begin
      if (rst) begin
        cnt_reg[t] <= COUNTER_RESET;
      end else if (tick[t]) begin
        cnt_reg[t] <= at_limit[t] ? COUNTER_RESET : cnt_reg[t] + 8'h01;
      end
    end

    // A match in the same cycle as a clear keeps the flag set.
    always_ff @(posedge clk) begin
      if (rst) begin
        flag_reg[t] <= 1'b0;
      end else if (tick[t] && at_limit[t]) begin
        flag_reg[t] <= 1'b1;
      end else if (flag_clear[t]) begin
        flag_reg[t] <= 1'b0;
      end
    end

    a_flag_on_match: assert property (@(posedge clk) disable iff (rst)
      tick[t] && at_limit[t] |=> timer_match_flag[t])
      else $error("match flag not set on counter reaching limit");
  end

  assign timer_match_flag = flag_reg;

  // ----------------------------------------------------------------------
  // Timer selection and the ten-bit time base
  // ----------------------------------------------------------------------
  logic               sel_valid;
  logic               sel_tick;
  logic               restart;
  logic [TIMER_W-1:0] sel_cnt;
  logic [SUB_W-1:0]   sel_sub;
  logic [BASE_W-1:0]  time_base;

  // An unused select code idles the channel rather than aliasing a timer.
  always_comb begin
    sel_valid = 32'(timer_source_select) < NUM_TIMERS;
    sel_tick  = 1'b0;
    restart   = 1'b0;
    sel_cnt   = COUNTER_RESET;
    sel_sub   = 2'h0;
    if (sel_valid) begin
      sel_tick = tick[timer_source_select];
      restart  = tick[timer_source_select] && at_limit[timer_source_select];
      sel_cnt  = cnt_reg[timer_source_select];
      sel_sub  = sub[timer_source_select];
    end
  end

  assign time_base = {sel_cnt, sel_sub};

  // ----------------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [TIMER_W-1:0] staging_reg;
  logic [TIMER_W-1:0] active_reg;
  logic [SUB_W-1:0]   latch_reg;
  logic               pwm_mode;
  logic [BASE_W-1:0]  duty_next;
  logic [BASE_W-1:0]  duty_act;

  assign pwm_mode  = (ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO] == PWM_MODE_TAG);
  assign duty_next = {staging_reg, ctrl_reg[CTRL_DUTY_HI:CTRL_DUTY_LO]};
  assign duty_act  = {active_reg, latch_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr_en) begin
      ctrl_reg <= ctrl_wr_data;
    end
  end

  // Staging may be written at any time; it only reaches the pin at a restart.
  always_ff @(posedge clk) begin
    if (rst) begin
      staging_reg <= DUTY_RESET;
    end else if (staging_wr_en) begin
      staging_reg <= staging_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= DUTY_RESET;
      latch_reg  <= 2'h0;
    end else if (pwm_mode && restart) begin
      active_reg <= staging_reg;
      latch_reg  <= ctrl_reg[CTRL_DUTY_HI:CTRL_DUTY_LO];
    end else if (!pwm_mode && active_wr_en) begin
      active_reg <= active_wr_data;
    end
  end

  assign channel_control    = ctrl_reg;
  assign duty_staging_upper = staging_reg;
  assign duty_active_upper  = active_reg;

  // ----------------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------------
  logic pin_reg;
  logic oe_reg;

  // A duty longer than the period never matches, so the pin simply stays set.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_reg <= 1'b0;
    end else if (!pwm_mode) begin
      pin_reg <= 1'b0;
    end else if (restart) begin
      if (duty_next != 10'h000) begin
        pin_reg <= 1'b1;
      end
    end else if (!sleep && time_base == duty_act) begin
      pin_reg <= 1'b0;
    end
  end

  // The driver also needs the direction bit cleared by software.
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= pwm_mode && !pin_direction_bit;
    end
  end

  assign pwm_output_pin = pin_reg;
  assign pwm_output_oe  = oe_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_restart_pwm;
    restart && pwm_mode;
  endsequence

  sequence s_same_select;
    timer_source_select == $past(timer_source_select);
  endsequence

  a_counter_wraps: assert property (
    restart ##1 s_same_select |-> sel_cnt == COUNTER_RESET)
    else $error("counter not cleared after reaching limit");

  a_step_spacing: assert property (
    sel_tick ##1 s_same_select |-> !sel_tick [*3])
    else $error("counter stepped faster than four clocks");

  a_pin_set: assert property (
    s_restart_pwm and (duty_next != 10'h000) |=> pwm_output_pin)
    else $error("pin not set at start of period");

  a_zero_duty: assert property (
    s_restart_pwm and (duty_next == 10'h000) |=> pwm_output_pin == $past(pwm_output_pin))
    else $error("pin set at period start with zero duty");

  a_duty_load: assert property (
    s_restart_pwm |=> duty_active_upper == $past(duty_staging_upper)
                      && latch_reg == $past(ctrl_reg[CTRL_DUTY_HI:CTRL_DUTY_LO]))
    else $error("staged duty not copied at restart");

  a_match_clear: assert property (
    pwm_mode && !restart && !sleep && time_base == duty_act |=> !pwm_output_pin)
    else $error("pin not cleared on duty match");

  a_active_hold: assert property (
    pwm_mode && !restart |=> $stable(duty_active_upper) && $stable(latch_reg))
    else $error("active duty changed outside a restart");

  a_pin_release: assert property (
    !pwm_mode |=> !pwm_output_oe && !pwm_output_pin)
    else $error("pin still driven outside pulse-width mode");

  a_sleep_freeze: assert property (
    sleep ##1 s_same_select |-> $stable(sel_cnt) && $stable(phase_reg)
                                && $stable(pwm_output_pin))
    else $error("channel state moved during sleep");

endmodule // spw_channel

// [rtl/spw_pkg.sv]
package spw_pkg;

  // ----------------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------------
  localparam int TIMER_W     = 8;
  localparam int SUB_W       = 2;
  localparam int BASE_W      = TIMER_W + SUB_W;
  localparam int NUM_TIMERS  = 3;
  localparam int SEL_W       = 2;
  localparam int CTRL_W      = 8;
  localparam int PRESC_W     = 4;

  // ----------------------------------------------------------------------
  // Channel control field layout and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_MODE_HI  = 3;
  localparam int CTRL_MODE_LO  = 2;
  localparam int CTRL_DUTY_HI  = 5;
  localparam int CTRL_DUTY_LO  = 4;
  localparam logic [1:0] PWM_MODE_TAG = 2'h3;
  localparam logic [CTRL_W-1:0]  CTRL_RESET    = 8'h00;
  localparam logic [TIMER_W-1:0] DUTY_RESET    = 8'h00;
  localparam logic [TIMER_W-1:0] COUNTER_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Time base: one counter step takes four clocks times the prescale ratio
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 5;
  localparam int CLKS_PER_STEP      = 4;
  localparam logic [SUB_W-1:0] PHASE_LAST = 2'(CLKS_PER_STEP - 1);
  localparam logic [1:0] PRESC_SEL_1  = 2'h0;
  localparam logic [1:0] PRESC_SEL_4  = 2'h1;
  localparam logic [PRESC_W-1:0] PRESC_LAST_1  = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_LAST_4  = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_LAST_16 = 4'hF;

endpackage
